// ---- cstx_pkg.sv ----
// Package: register map, field positions, reset values and types for the CAN status block
// How it works
// - Count messages: up on receive, down on release
// - Message count read-only, reset clears, five bits
// - Status register at offset two, read-only, live
// - Bit seven shows bus-off state
// - Bit six: any counter at warning limit
// - Bit five transmitting, bit four receiving
// - Bit three: last transmission completed
// - Bit two: transmit buffer released for software
// - Bit one: overrun sticky until clear command
// - Bit zero: message waiting in FIFO
// - Thirteen byte buffer, write 10h, read 60h
// - Byte zero frame info; standard/extended data start
// - Transmit counter: up on errors, down on success
// - Warning interrupt once, unless receive counter did
// - Above 127: error passive, passive interrupt unless receive counter already above 127
// - Above 255 without lone node: bus-off, reset mode, warning interrupt
// - Bus-off loads 127, counts 128 bus-free sequences
// - Reset mode during recovery freezes counter
// - Counter writable only in reset mode
// - Write 0..254 in bus-off clears flag
// - Write 255 schedules forced bus-off
// - Forced bus-off recovers through full sequence
package cstx_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_TRANSMIT_ERROR_COUNTER = 8'h0F;
    localparam logic [7:0] ADDR_TXBUF_W = 8'h10;
    localparam logic [7:0] ADDR_RMC = 8'h1D;
    localparam logic [7:0] ADDR_TXBUF_R = 8'h60;
    localparam int TXBUF_LEN = 13;
    localparam logic [7:0] TXBUF_LAST = 8'h0C;
    localparam logic [7:0] SFF_DATA_IDX = 8'h03;
    localparam logic [7:0] EFF_DATA_IDX = 8'h05;
    localparam int FI_EFF_BIT = 7;
    localparam int FI_RTR_BIT = 6;
    localparam logic [7:0] PASSIVE_LIM = 8'h7F;
    localparam logic [7:0] RECOV_LOAD = 8'h7F;
    localparam logic [8:0] BUSOFF_LIM = 9'h0FF;
    localparam logic [7:0] FORCE_VAL = 8'hFF;
    localparam logic [7:0] EWL_RESET = 8'h60;
    localparam logic [7:0] ERRINC_STEP = 8'h08;
    localparam logic [4:0] RMC_RESET = 5'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int SR_BS = 7;
    localparam int SR_ES = 6;
    localparam int SR_TS = 5;
    localparam int SR_RS = 4;
    localparam int SR_TCS = 3;
    localparam int SR_TBS = 2;
    localparam int SR_DOS = 1;
    localparam int SR_RBS = 0;
    // Recovery state machine
    typedef enum logic [2:0] {
        CSTX_RUN = 3'b001,
        CSTX_BOFF = 3'b010,
        CSTX_FORCE = 3'b100
    } cstx_boff_t;
    // Protocol engine events, one-cycle pulses except the txActive and rxActive levels
    typedef struct packed {
        logic rxDone;
        logic rxLost;
        logic txOk;
        logic transmit_error_counter;
        logic txErrBit;
        logic busFree;
        logic txActive;
        logic rxActive;
        logic loneNode;
    } cstx_evt_t;
    // Software commands, one-cycle pulses except the resetMode level
    typedef struct packed {
        logic releaseRx;
        logic clearOverrun;
        logic txRequest;
        logic softReset;
        logic resetMode;
    } cstx_cmd_t;
endpackage : cstx_pkg

// ---- cstx_transmit_error_counter.sv ----
// Transmit error counter with bus-off entry and recovery
`timescale 1ns/1ps
module cstx_transmit_error_counter
    import cstx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Events and mode
    input wire cstx_evt_t evt,
    input wire logic resetMode,
    input wire logic [7:0] errorWarningLimit,
    input wire logic [7:0] rxErrCount,
    // Software write
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    // State out
    output logic [7:0] count,
    output logic busOff,
    output logic passive,
    output logic enterResetMode,
    output logic warnEvent,
    output logic passiveEvent
);
    typedef struct packed {
        logic [7:0] cnt;
        cstx_boff_t st;
        logic pass;
        logic warnSeen;
        logic oneShot;
    } cstx_te_t;
    cstx_te_t st_ff, nxt_st;
    logic [8:0] sum;
    // Next-state logic for counter and bus-off
    always_comb begin
        nxt_st = st_ff;
        sum = {1'b0, st_ff.cnt};
        enterResetMode = 1'b0;
        warnEvent = 1'b0;
        passiveEvent = 1'b0;
        unique case (st_ff.st)
            CSTX_RUN: begin
                if (resetMode && wrEn) begin
                    if (wrData == FORCE_VAL) nxt_st.st = CSTX_FORCE;
                    else nxt_st.cnt = wrData;
                end else if (!resetMode) begin
                    if (evt.transmit_error_counter) sum = {1'b0, st_ff.cnt} + {1'b0, ERRINC_STEP};
                    else if (evt.txOk && st_ff.cnt != 8'h00) sum = {1'b0, st_ff.cnt} - 9'h001;
                    if (sum > BUSOFF_LIM && !evt.loneNode) begin
                        nxt_st.st = CSTX_BOFF;
                        nxt_st.cnt = RECOV_LOAD;
                        nxt_st.oneShot = 1'b0;
                        enterResetMode = 1'b1;
                        warnEvent = 1'b1;
                    end else begin
                        nxt_st.cnt = (sum > BUSOFF_LIM) ? 8'hFF : sum[7:0];
                        if (sum[7:0] > PASSIVE_LIM && !st_ff.pass) begin
                            nxt_st.pass = 1'b1;
                            passiveEvent = (rxErrCount <= PASSIVE_LIM);
                        end else if (sum[7:0] <= PASSIVE_LIM && rxErrCount <= PASSIVE_LIM) begin
                            nxt_st.pass = 1'b0;
                        end
                        if (sum[7:0] >= errorWarningLimit && !st_ff.warnSeen) begin
                            nxt_st.warnSeen = 1'b1;
                            warnEvent = (rxErrCount < errorWarningLimit);
                        end else if (sum[7:0] < errorWarningLimit) begin
                            nxt_st.warnSeen = 1'b0;
                        end
                    end
                end
            end
            CSTX_BOFF: begin
                if (resetMode) begin
                    if (wrEn && wrData != FORCE_VAL) begin
                        nxt_st.oneShot = 1'b1;
                        nxt_st.cnt = wrData;
                    // forced bus-off scheduled from bus-off too
                    end else if (wrEn) begin
                        nxt_st.st = CSTX_FORCE;
                        nxt_st.oneShot = 1'b0;
                    end
                end else if (evt.busFree) begin
                    if (st_ff.oneShot || st_ff.cnt == 8'h00) begin
                        nxt_st = '{cnt: 8'h00, st: CSTX_RUN, pass: 1'b0, warnSeen: 1'b0, oneShot: 1'b0};
                    end else begin
                        nxt_st.cnt = st_ff.cnt - 8'h01;
                    end
                end
            end
            CSTX_FORCE: begin
                // forced bus-off on leaving reset mode
                if (!resetMode) begin
                    nxt_st.st = CSTX_BOFF;
                    nxt_st.cnt = RECOV_LOAD;
                    nxt_st.oneShot = 1'b0;
                    enterResetMode = 1'b1;
                    warnEvent = 1'b1;
                end
            end
            default: nxt_st.st = CSTX_RUN;
        endcase
    end
    // State register
    always_ff @(posedge clk) begin
        if (rst) st_ff <= '{cnt: 8'h00, st: CSTX_RUN, pass: 1'b0, warnSeen: 1'b0, oneShot: 1'b0};
        else st_ff <= nxt_st;
    end
    assign count = st_ff.cnt;
    // an early recovery write drops the flag
    assign busOff = (st_ff.st == CSTX_BOFF) && !st_ff.oneShot;
    assign passive = st_ff.pass;
    boff_load_a: assert property (@(posedge clk) disable iff (rst)
        (!busOff ##1 busOff) |-> (st_ff.cnt == RECOV_LOAD))
        else $error("bus-off entry did not load recovery count");
    boff_freeze_a: assert property (@(posedge clk) disable iff (rst)
        (busOff && resetMode && !wrEn) |=> (st_ff.cnt == $past(st_ff.cnt)))
        else $error("counter moved during bus-off in reset mode");
    te_readonly_a: assert property (@(posedge clk) disable iff (rst)
        (st_ff.st == CSTX_RUN && !resetMode && wrEn && !evt.transmit_error_counter && !evt.txOk)
        |=> (st_ff.cnt == $past(st_ff.cnt)))
        else $error("counter written in operating mode");
endmodule : cstx_transmit_error_counter

// ---- cstx_top.sv ----
// CAN status, transmit buffer and transmit error counter behind AXI4-Lite
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module cstx_top
    import cstx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write channels
    input wire logic [8:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [8:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Protocol engine and command side
    input wire cstx_evt_t evt,
    input wire cstx_cmd_t cmd,
    input wire logic [7:0] errorWarningLimit,
    input wire logic [7:0] rxErrCount,
    // Results toward engine and interrupt logic
    output logic [7:0] txFrameInfo,
    output logic [7:0] txDataStart,
    output logic txPending,
    output logic busOffEnterReset,
    output logic errWarnPulse,
    output logic errPassivePulse,
    output logic clearRxErr
);
    typedef struct packed {
        logic [7:0] awAddr;
        logic awHave;
        logic [7:0] wData;
        logic wHave;
        logic awRdy;
        logic wRdy;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [4:0] msgCnt;
        logic overrun;
        logic txDone;
        logic txLock;
        logic [7:0] statusQ;
        logic [7:0] dataStart;
        logic enterRst;
        logic warnP;
        logic passP;
        logic clrRx;
    } cstx_st_t;
    cstx_st_t st_ff, nxt_st;
    logic [7:0] txBuf_ff [TXBUF_LEN];
    logic [7:0] teCount;
    logic teBusOff;
    logic tePassive;
    logic teEnter;
    logic teWarn;
    logic tePass;
    logic wrFire;
    logic teWrite;
    logic bufWrite;
    logic [7:0] bufIdx;
    logic [7:0] statusNow;
    logic [7:0] rdIdx;
    logic [7:0] arIdx;
    logic [7:0] bufRead;
    // Counter and bus-off engine
    cstx_transmit_error_counter u_transmit_error_counter (
        .clk(clk),
        .rst(rst),
        .evt(evt),
        .resetMode(cmd.resetMode),
        .errorWarningLimit(errorWarningLimit),
        .rxErrCount(rxErrCount),
        .wrEn(teWrite),
        .wrData(st_ff.wData),
        .count(teCount),
        .busOff(teBusOff),
        .passive(tePassive),
        .enterResetMode(teEnter),
        .warnEvent(teWarn),
        .passiveEvent(tePass)
    );
    // Write decode, fires once both halves are held
    assign wrFire = st_ff.awHave && st_ff.wHave && !st_ff.bValid;
    assign teWrite = wrFire && st_ff.awAddr == ADDR_TRANSMIT_ERROR_COUNTER;
    assign bufIdx = st_ff.awAddr - ADDR_TXBUF_W;
    assign bufWrite = wrFire && st_ff.awAddr >= ADDR_TXBUF_W && bufIdx <= TXBUF_LAST && !st_ff.txLock;
    always_comb begin
        statusNow = 8'h00;
        statusNow[SR_BS] = teBusOff;
        statusNow[SR_ES] = (teCount >= errorWarningLimit) || (rxErrCount >= errorWarningLimit);
        statusNow[SR_TS] = evt.txActive;
        statusNow[SR_RS] = evt.rxActive;
        statusNow[SR_TCS] = st_ff.txDone;
        statusNow[SR_TBS] = !st_ff.txLock;
        statusNow[SR_DOS] = st_ff.overrun;
        statusNow[SR_RBS] = (st_ff.msgCnt != 5'h00);
    end
    assign arIdx = {1'b0, s_axi_araddr[8:2]};
    assign rdIdx = arIdx - ADDR_TXBUF_R;
    assign bufRead = txBuf_ff[rdIdx[3:0]];
    // Next-state logic for bus slave and flags
    always_comb begin
        nxt_st = st_ff;
        // Write address and data taken in either order
        if (s_axi_awvalid && st_ff.awRdy) begin
            nxt_st.awAddr = {1'b0, s_axi_awaddr[8:2]};
            nxt_st.awHave = 1'b1;
        end
        if (s_axi_wvalid && st_ff.wRdy) begin
            nxt_st.wData = s_axi_wdata[7:0];
            nxt_st.wHave = 1'b1;
            if (!s_axi_wstrb[0]) nxt_st.wData = 8'h00;
        end
        if (wrFire) begin
            nxt_st.bValid = 1'b1;
            nxt_st.bResp = RESP_OKAY;
            if (st_ff.awAddr == ADDR_STATUS || st_ff.awAddr == ADDR_RMC) nxt_st.bResp = RESP_OKAY;
            else if (!(teWrite || bufWrite)) nxt_st.bResp = RESP_SLVERR;
        end
        if (st_ff.bValid && s_axi_bready) begin
            nxt_st.bValid = 1'b0;
            nxt_st.awHave = 1'b0;
            nxt_st.wHave = 1'b0;
        end
        // Read channel, one cycle after address
        nxt_st.arReady = 1'b0;
        if (s_axi_arvalid && !st_ff.arReady && !st_ff.rValid) begin
            nxt_st.arReady = 1'b1;
            nxt_st.rValid = 1'b1;
            nxt_st.rResp = RESP_OKAY;
            nxt_st.rData = 32'h0000_0000;
            if (arIdx == ADDR_STATUS) nxt_st.rData[7:0] = statusNow;
            else if (arIdx == ADDR_TRANSMIT_ERROR_COUNTER) nxt_st.rData[7:0] = teCount;
            else if (arIdx == ADDR_RMC) nxt_st.rData[7:0] = {3'b000, st_ff.msgCnt};
            else if (arIdx >= ADDR_TXBUF_R && rdIdx <= TXBUF_LAST) nxt_st.rData[7:0] = bufRead;
            else nxt_st.rResp = RESP_SLVERR;
        end else if (st_ff.rValid && s_axi_rready) begin
            nxt_st.rValid = 1'b0;
        end
        if (evt.rxDone && !cmd.releaseRx) nxt_st.msgCnt = st_ff.msgCnt + 5'h01;
        else if (cmd.releaseRx && !evt.rxDone && st_ff.msgCnt != 5'h00) nxt_st.msgCnt = st_ff.msgCnt - 5'h01;
        if (evt.rxLost) nxt_st.overrun = 1'b1;
        else if (cmd.clearOverrun) nxt_st.overrun = 1'b0;
        if (evt.txOk) nxt_st.txDone = 1'b1;
        else if (cmd.txRequest) nxt_st.txDone = 1'b0;
        if (evt.txOk || teEnter) nxt_st.txLock = 1'b0;
        else if (cmd.txRequest) nxt_st.txLock = 1'b1;
        if (cmd.softReset) nxt_st.msgCnt = RMC_RESET;
        nxt_st.statusQ = statusNow;
        nxt_st.dataStart = txBuf_ff[0][FI_EFF_BIT] ? EFF_DATA_IDX : SFF_DATA_IDX;
        nxt_st.enterRst = teEnter;
        nxt_st.warnP = teWarn;
        nxt_st.passP = tePass;
        nxt_st.clrRx = teEnter;
        // Ready flags kept in flops so bus outputs come from registers
        nxt_st.awRdy = !nxt_st.awHave;
        nxt_st.wRdy = !nxt_st.wHave;
    end
    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < TXBUF_LEN; i++) begin
                txBuf_ff[i] <= 8'h00;
            end
        end else if (bufWrite) begin
            txBuf_ff[bufIdx[3:0]] <= st_ff.wData;
        end
    end
    // Registered outputs
    assign s_axi_awready = st_ff.awRdy;
    assign s_axi_wready = st_ff.wRdy;
    assign s_axi_bvalid = st_ff.bValid;
    assign s_axi_bresp = st_ff.bResp;
    assign s_axi_arready = st_ff.arReady;
    assign s_axi_rvalid = st_ff.rValid;
    assign s_axi_rdata = st_ff.rData;
    assign s_axi_rresp = st_ff.rResp;
    assign txFrameInfo = txBuf_ff[0];
    assign txDataStart = st_ff.dataStart;
    assign txPending = st_ff.txLock;
    assign busOffEnterReset = st_ff.enterRst;
    assign errWarnPulse = st_ff.warnP;
    assign errPassivePulse = st_ff.passP;
    assign clearRxErr = st_ff.clrRx;
    rmc_count_a: assert property (@(posedge clk) disable iff (rst)
        (evt.rxDone && !cmd.releaseRx && !cmd.softReset) |=> (st_ff.msgCnt == $past(st_ff.msgCnt) + 5'h01))
        else $error("message count did not rise on receive");
    ovr_sticky_a: assert property (@(posedge clk) disable iff (rst)
        (st_ff.overrun && !cmd.clearOverrun) |=> st_ff.overrun)
        else $error("overrun flag dropped without clear");
    rbs_track_a: assert property (@(posedge clk) disable iff (rst)
        (evt.rxDone && !cmd.releaseRx && !cmd.softReset) |=> statusNow[SR_RBS])
        else $error("message waiting bit wrong");
    tbs_lock_a: assert property (@(posedge clk) disable iff (rst)
        st_ff.txLock |=> $stable(txBuf_ff[0]))
        else $error("buffer written while locked");
    rmc_clear_a: assert property (@(posedge clk) disable iff (rst)
        cmd.softReset |=> st_ff.msgCnt == RMC_RESET)
        else $error("software reset left message count");
endmodule : cstx_top

// ---- cstx_partner.sv ----
// Partner model: CAN bus side of the status block, as seen by the protocol engine
`timescale 1ns/1ps
module cstx_partner
    import cstx_pkg::*;
(
    // Clock
    input wire logic clk,
    // Events toward the block
    output cstx_evt_t evt
);
    cstx_evt_t lvl;
    // Quiet bus at start: no pulses, no activity
    initial begin
        lvl = '0;
        evt = '0;
    end
    task automatic fire(input cstx_evt_t p, input int n);
        repeat (n) begin
            evt <= lvl | p;
            @(posedge clk);
            evt <= lvl;
            @(posedge clk);
        end
    endtask : fire
    task automatic level(input logic tx, input logic rx);
        lvl.txActive = tx;
        lvl.rxActive = rx;
        evt <= lvl;
        @(posedge clk);
    endtask : level
endmodule : cstx_partner

// ---- tb_top.sv ----
// Testbench: register bus, event and recovery scenarios for the status block
`timescale 1ns/1ps
module tb_top;
    import cstx_pkg::*;
    localparam logic [8:0] A_SR = {ADDR_STATUS[6:0], 2'b00};
    localparam logic [8:0] A_TE = {ADDR_TRANSMIT_ERROR_COUNTER[6:0], 2'b00};
    localparam logic [8:0] A_RMC = {ADDR_RMC[6:0], 2'b00};
    localparam logic [8:0] A_TBW = {ADDR_TXBUF_W[6:0], 2'b00};
    localparam logic [8:0] A_TBR = {ADDR_TXBUF_R[6:0], 2'b00};
    localparam logic [31:0] M_BS = 32'h1 << SR_BS;
    localparam logic [31:0] M_ES = 32'h1 << SR_ES;
    localparam logic [31:0] M_TR = (32'h1 << SR_TS) | (32'h1 << SR_RS);
    localparam logic [31:0] M_TB = (32'h1 << SR_TCS) | (32'h1 << SR_TBS);
    localparam logic [31:0] M_DOS = 32'h1 << SR_DOS;
    localparam logic [31:0] M_RBS = 32'h1 << SR_RBS;
    localparam cstx_evt_t E_RXD = 9'h100;
    localparam cstx_evt_t E_LOST = 9'h080;
    localparam cstx_evt_t E_OK = 9'h040;
    localparam cstx_evt_t E_ERR = 9'h020;
    localparam cstx_evt_t E_FREE = 9'h008;
    typedef struct {bit isRd; logic [31:0] exp; logic [31:0] msk; logic [1:0] resp;} cstx_note_t;
    logic clk, rst;
    logic [8:0] s_axi_awaddr, s_axi_araddr;
    logic [7:0] errorWarningLimit, rxErrCount, txFrameInfo, txDataStart, fi;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, txPending;
    logic busOffEnterReset, errWarnPulse, errPassivePulse, clearRxErr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    cstx_evt_t evt;
    cstx_cmd_t cmd;
    cstx_note_t notes[$];
    cstx_note_t nt;
    int miscompares, testsRun, seed, cycles, boCnt, warnCnt, pasCnt, clrCnt;
    cstx_top u_cstx_top (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .evt(evt),
        .cmd(cmd), .errorWarningLimit(errorWarningLimit), .rxErrCount(rxErrCount), .txFrameInfo(txFrameInfo),
        .txDataStart(txDataStart), .txPending(txPending), .busOffEnterReset(busOffEnterReset),
        .errWarnPulse(errWarnPulse), .errPassivePulse(errPassivePulse), .clearRxErr(clearRxErr));
    cstx_partner u_cstx_partner (.clk(clk), .evt(evt));
    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cmpData(input string nm, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : cmpData
    task automatic cmpResp(input logic [1:0] e, input logic [1:0] g);
        testsRun++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH resp expected %h seen %h", e, g);
        end
    endtask : cmpResp
    task automatic report_and_stop;
        if (miscompares == 0 && testsRun > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop
    // Bus write: address and data offered together, each dropped once taken
    task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic [1:0] r);
        notes.push_back('{1'b0, 32'h0, 32'h0, r});
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask : wr
    // Bus read: expectation noted before the request goes out
    task automatic rd(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] r);
        notes.push_back('{1'b1, e, m, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        // Idle edge so a following read does not re-raise arvalid at once
        @(posedge clk);
    endtask : rd
    // One-cycle software command
    task automatic cp(input cstx_cmd_t p);
        cmd <= cmd | p;
        @(posedge clk);
        cmd <= cmd & 5'h01;
        @(posedge clk);
    endtask : cp
    // Result watcher: oldest note against each answer
    always @(posedge clk) begin
        if ((s_axi_rvalid || s_axi_bvalid) && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt.isRd) cmpData("rdata", nt.exp & nt.msk, s_axi_rdata & nt.msk);
            cmpResp(nt.resp, nt.isRd ? s_axi_rresp : s_axi_bresp);
        end
    end
    // Pulse counters and run ceiling
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            report_and_stop;
        end
        if (!rst) begin
            boCnt <= boCnt + int'(busOffEnterReset);
            warnCnt <= warnCnt + int'(errWarnPulse);
            pasCnt <= pasCnt + int'(errPassivePulse);
            clrCnt <= clrCnt + int'(clearRxErr);
        end
    end
    // Main sequence
    initial begin
        {miscompares, testsRun, cycles, boCnt, warnCnt, pasCnt, clrCnt} = '0;
        seed = 90;
        rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        cmd = '0;
        errorWarningLimit = EWL_RESET;
        rxErrCount = 8'h00;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rxErrCount <= 8'($random(seed)) & 8'h3F;
        fi = 8'($random(seed));
        rd(A_RMC, 32'h0, 32'hFF, RESP_OKAY);
        rd(A_TE, 32'h0, 32'hFF, RESP_OKAY);
        rd(A_SR, 32'h0, M_BS | M_ES | M_TR | M_DOS | M_RBS, RESP_OKAY);
        rd(9'h0F0, 32'h0, 32'h0, RESP_SLVERR);
        wr(A_TE, 8'h33, RESP_OKAY);
        rd(A_TE, 32'h0, 32'hFF, RESP_OKAY);
        u_cstx_partner.fire(E_RXD, 3);
        rd(A_RMC, 32'h3, 32'hFF, RESP_OKAY);
        rd(A_SR, M_RBS, M_RBS, RESP_OKAY);
        cp(C_REL());
        rd(A_RMC, 32'h2, 32'hFF, RESP_OKAY);
        wr(A_RMC, 8'h1F, RESP_OKAY);
        wr(A_SR, 8'hFF, RESP_OKAY);
        rd(A_RMC, 32'h2, 32'hFF, RESP_OKAY);
        rd(A_SR, M_RBS, M_BS | M_DOS | M_RBS, RESP_OKAY);
        cp(5'h02);
        rd(A_RMC, 32'h0, 32'hFF, RESP_OKAY);
        rd(A_SR, 32'h0, M_RBS, RESP_OKAY);
        u_cstx_partner.fire(E_LOST, 1);
        rd(A_SR, M_DOS, M_DOS, RESP_OKAY);
        cp(5'h08);
        rd(A_SR, 32'h0, M_DOS, RESP_OKAY);
        wr(A_TBW, fi, RESP_OKAY);
        rd(A_TBR, {24'h0, fi}, 32'hFF, RESP_OKAY);
        cmpData("frameInfo", {24'h0, fi}, {24'h0, txFrameInfo});
        cmpData("dataStart", {24'h0, fi[FI_EFF_BIT] ? EFF_DATA_IDX : SFF_DATA_IDX}, {24'h0, txDataStart});
        cp(5'h04);
        rd(A_SR, 32'h0, M_TB, RESP_OKAY);
        cmpData("txPending", 32'h1, {31'h0, txPending});
        wr(A_TBW, ~fi, RESP_SLVERR);
        rd(A_TBR, {24'h0, fi}, 32'hFF, RESP_OKAY);
        u_cstx_partner.level(1'b1, 1'b1);
        rd(A_SR, M_TR, M_TR, RESP_OKAY);
        u_cstx_partner.level(1'b0, 1'b0);
        u_cstx_partner.fire(E_OK, 1);
        rd(A_SR, M_TB, M_TB | M_TR, RESP_OKAY);
        u_cstx_partner.fire(E_ERR, 11);
        rd(A_TE, 32'h58, 32'hFF, RESP_OKAY);
        rd(A_SR, 32'h0, M_ES, RESP_OKAY);
        u_cstx_partner.fire(E_ERR, 1);
        rd(A_SR, M_ES, M_ES, RESP_OKAY);
        cmpData("warnCnt", 32'h1, warnCnt);
        u_cstx_partner.fire(E_OK, 1);
        rd(A_TE, 32'h5F, 32'hFF, RESP_OKAY);
        u_cstx_partner.fire(E_ERR, 21);
        repeat (3) @(posedge clk);
        cmpData("passiveCnt", 32'h1, pasCnt);
        cmpData("busOffCnt", 32'h1, boCnt);
        cmd.resetMode <= 1'b1;
        rd(A_TE, {24'h0, RECOV_LOAD}, 32'hFF, RESP_OKAY);
        rd(A_SR, M_BS, M_BS, RESP_OKAY);
        u_cstx_partner.fire(E_FREE, 4);
        rd(A_TE, {24'h0, RECOV_LOAD}, 32'hFF, RESP_OKAY);
        cmd.resetMode <= 1'b0;
        u_cstx_partner.fire(E_FREE, 4);
        rd(A_TE, {24'h0, RECOV_LOAD - 8'h04}, 32'hFF, RESP_OKAY);
        cmd.resetMode <= 1'b1;
        u_cstx_partner.fire(E_FREE, 3);
        rd(A_TE, {24'h0, RECOV_LOAD - 8'h04}, 32'hFF, RESP_OKAY);
        wr(A_TE, 8'h0A, RESP_OKAY);
        rd(A_SR, 32'h0, M_BS, RESP_OKAY);
        wr(A_TE, FORCE_VAL, RESP_OKAY);
        cmd.resetMode <= 1'b0;
        repeat (4) @(posedge clk);
        cmd.resetMode <= 1'b1;
        cmpData("busOffCnt", 32'h2, boCnt);
        cmpData("clearRxCnt", 32'h2, clrCnt);
        rd(A_TE, {24'h0, RECOV_LOAD}, 32'hFF, RESP_OKAY);
        rd(A_SR, M_BS, M_BS, RESP_OKAY);
        cmd.resetMode <= 1'b0;
        u_cstx_partner.fire(E_FREE, 128);
        rd(A_TE, 32'h0, 32'hFF, RESP_OKAY);
        rd(A_SR, 32'h0, M_BS, RESP_OKAY);
        report_and_stop;
    end
    function automatic cstx_cmd_t C_REL();
        return 5'h10;
    endfunction : C_REL
endmodule : tb_top
